// [hw/fpec_regs.svh]
// offsets, field positions, key values and timing counts of the flash control
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FPEC_CTRL_OFS 8'h00
`define FPEC_KEY_OFS 8'h04
`define FPEC_PAGE_OFS 8'h08
`define FPEC_OFFS_OFS 8'h0C
`define FPEC_LATCH_OFS 8'h10
// ---------------------------------------------------------------
// fields, keys and codes
// ---------------------------------------------------------------
`define FPEC_WR_BIT 15
`define FPEC_PROGRAM_ERASE_ENABLE_BIT 14
`define FPEC_ERR_BIT 13
`define FPEC_ERASE_BIT 6
`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'hAA
`define FPEC_OP_BULK 4'hF
`define FPEC_OP_WORD 4'h3
`define FPEC_OP_PAGE 4'h2
`define FPEC_OP_ROW 4'h1
`define FPEC_ROW_WORDS 7'h40
`define FPEC_ROW_MASK 24'h00007F
`define FPEC_BLOCK_MASK 24'h0003FF
// ---------------------------------------------------------------
// timing: least times in ns, rounded up to 4 ns cycles
// ---------------------------------------------------------------
`define FPEC_CLK_NS 4
`define FPEC_WORD_TIME_NS 400
`define FPEC_ROW_TIME_NS 2000
`define FPEC_PAGE_TIME_NS 20000
`define FPEC_BULK_TIME_NS 40000
`define FPEC_CYC(t) (((t) + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS)
`endif

// [hw/fpec_pkg.sv]
// types shared by the flash program/erase control
package fpec_pkg;
	typedef enum logic [1:0] {
		FPEC_IDLE = 2'b00,
		FPEC_STREAM = 2'b01,
		FPEC_WAIT = 2'b11
	} fpec_state_e;
	typedef logic [23:0] fpec_word_t;
endpackage

// [hw/fpec_top.sv]
// flash program/erase sequencer with unlock keys and write latches
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"
module fpec_top import fpec_pkg::*; #(
	parameter int PAGE_CYCLES = `FPEC_CYC(`FPEC_PAGE_TIME_NS), // erase time
	parameter int BULK_CYCLES = `FPEC_CYC(`FPEC_BULK_TIME_NS)  // bulk time
) (
	input wire logic aclk, // 250 MHz clock
	input wire logic aresetn, // power-on reset, sync, low
	input wire logic sys_reset_req, // other reset source, same clock
	input wire logic serial_prog_pin, // serial programming mode pin
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	output logic cpu_stall, // processor held while busy
	output logic flash_erase, // one-cycle erase strobe
	output logic flash_bulk, // erase covers whole array
	output logic flash_wr_en, // one word written this cycle
	output logic [23:0] flash_addr, // array address
	output logic [23:0] flash_wdata // array write data
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic wr_reg, program_erase_enable_reg, err_reg, erase_reg; // control bits
	logic [3:0] op_reg; // operation_select
	logic [1:0] key_reg; // 0 none, 1 first key, 2 armed
	logic [7:0] page_reg; // table_page
	logic [15:0] offs_reg; // table_store offset
	fpec_word_t latch_mem [64]; // holding latches
	fpec_state_e state_reg; // sequencer state
	logic [15:0] cnt_reg; // remaining busy cycles
	logic [6:0] idx_reg; // latch being streamed
	logic last_reg; // stream ends after this word
	logic [23:0] base_reg; // operation base address
	logic [1:0] ser_sync; // pin synchroniser
	logic [7:0] waddr_reg, raddr_reg; // held addresses
	logic aw_held, w_held; // write halves held
	logic [31:0] wd_reg; // held write data
	logic [3:0] ws_reg; // held strobes
	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic wr_fire, map_w, map_r; // write commit, decodes
	assign awready = !aw_held;
	assign wready = !w_held;
	assign arready = !rvalid;
	assign wr_fire = aw_held && w_held && !bvalid;
	assign map_w = waddr_reg[1:0] == 2'h0 && waddr_reg <= `FPEC_LATCH_OFS;
	assign map_r = araddr[1:0] == 2'h0 && araddr <= `FPEC_LATCH_OFS;
	// catch address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			waddr_reg <= 8'h00;
			wd_reg <= 32'h0;
			ws_reg <= 4'h0;
		end else if (wr_fire) begin // both consumed
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				waddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wd_reg <= wdata;
				ws_reg <= wstrb;
			end
		end
	end
	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= map_w ? 2'h0 : 2'h2; // slverr when unmapped
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end
	// read path, registered data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
			raddr_reg <= 8'h00;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			raddr_reg <= araddr;
			rresp <= map_r ? 2'h0 : 2'h2;
			case (araddr)
				`FPEC_CTRL_OFS: rdata <= {16'h0, wr_reg, program_erase_enable_reg, err_reg,
					6'h0, erase_reg, 2'h0, op_reg};
				`FPEC_KEY_OFS: rdata <= 32'h0;
				`FPEC_PAGE_OFS: rdata <= {24'h0, page_reg};
				`FPEC_OFFS_OFS: rdata <= {16'h0, offs_reg};
				`FPEC_LATCH_OFS: rdata <= {8'h0, latch_mem[offs_reg[6:1]]};
				default: rdata <= 32'h0;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// decode of software actions
	// ---------------------------------------------------------------
	logic busy, ctl_w, key_w, set_try, legal, noop, go, bad, done, abort;
	logic ser_mode; // synchronised serial mode
	assign busy = state_reg != FPEC_IDLE;
	assign ser_mode = ser_sync[1];
	assign ctl_w = wr_fire && waddr_reg == `FPEC_CTRL_OFS;
	assign key_w = wr_fire && waddr_reg == `FPEC_KEY_OFS && ws_reg[0];
	assign set_try = ctl_w && ws_reg[1] && wd_reg[`FPEC_WR_BIT] && !busy;
	assign abort = sys_reset_req && busy;
	// code and selector decide the action
	always_comb begin
		legal = 1'b1;
		noop = 1'b0;
		case (op_reg)
			`FPEC_OP_BULK: begin
				legal = ser_mode || !erase_reg;
				noop = !erase_reg;
			end
			`FPEC_OP_WORD: noop = erase_reg;
			`FPEC_OP_PAGE: noop = !erase_reg;
			`FPEC_OP_ROW: noop = erase_reg;
			default: legal = 1'b0;
		endcase
	end
	assign go = set_try && key_reg == 2'h2 && program_erase_enable_reg && legal;
	assign bad = set_try && !go;
	assign done = busy && state_reg != FPEC_STREAM && cnt_reg == 16'h0;
	// ---------------------------------------------------------------
	// unlock key tracking
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_reset_req) begin
			key_reg <= 2'h0;
		end else if (key_w) begin
			if (wd_reg[7:0] == `FPEC_KEY_FIRST) begin
				key_reg <= 2'h1;
			end else if (wd_reg[7:0] == `FPEC_KEY_SECOND && key_reg == 2'h1) begin
				key_reg <= 2'h2;
			end else begin
				key_reg <= 2'h0;
			end
		end else if (wr_fire) begin // any other write disarms
			key_reg <= 2'h0;
		end
	end
	// ---------------------------------------------------------------
	// control register, power-on reset only
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_erase_enable_reg <= 1'b0;
			erase_reg <= 1'b0;
			op_reg <= 4'h0;
		end else if (ctl_w && !busy) begin
			if (ws_reg[1]) begin
				program_erase_enable_reg <= wd_reg[`FPEC_PROGRAM_ERASE_ENABLE_BIT];
			end
			if (ws_reg[0]) begin
				erase_reg <= wd_reg[`FPEC_ERASE_BIT];
				op_reg <= wd_reg[3:0];
			end
		end
	end
	// error flag, hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_reg <= 1'b0;
		end else if (bad || abort) begin
			err_reg <= 1'b1;
		end else if (ctl_w && ws_reg[1] && !busy) begin
			err_reg <= wd_reg[`FPEC_ERR_BIT];
		end
	end
	// trigger bit: software only sets, hardware clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_reg <= 1'b0;
		end else if (go) begin
			wr_reg <= 1'b1;
		end else if (done || abort) begin
			wr_reg <= 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// table page, offset and holding latches
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_reg <= 8'h00;
			offs_reg <= 16'h0;
		end else if (wr_fire && ws_reg[0] && !busy) begin
			if (waddr_reg == `FPEC_PAGE_OFS) begin
				page_reg <= wd_reg[7:0];
			end else if (waddr_reg == `FPEC_OFFS_OFS) begin
				offs_reg <= wd_reg[15:0];
			end else if (waddr_reg == `FPEC_LATCH_OFS) begin
				offs_reg <= offs_reg + 16'h2; // next instruction
			end
		end
	end
	// data waits here until a trigger commits it
	always_ff @(posedge aclk) begin
		if (wr_fire && ws_reg[0] && !busy && waddr_reg == `FPEC_LATCH_OFS) begin
			latch_mem[offs_reg[6:1]] <= wd_reg[23:0];
		end
	end
	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	logic [23:0] tab_addr; // table pointer
	assign tab_addr = {page_reg, offs_reg};
	always_ff @(posedge aclk) begin
		ser_sync <= {ser_sync[0], serial_prog_pin};
	end
	// launch, stream latches, then wait out the self-timed cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || abort) begin
			state_reg <= FPEC_IDLE;
			cnt_reg <= 16'h0;
			idx_reg <= 7'h0;
			last_reg <= 1'b0;
			base_reg <= 24'h0;
		end else begin
			case (state_reg)
				FPEC_IDLE: begin
					if (go) begin
						idx_reg <= 7'h0;
						state_reg <= FPEC_WAIT;
						cnt_reg <= 16'h0;
						if (!noop && op_reg == `FPEC_OP_ROW) begin
							state_reg <= FPEC_STREAM;
							base_reg <= tab_addr & ~`FPEC_ROW_MASK;
							last_reg <= 1'b0;
							cnt_reg <= 16'(`FPEC_CYC(`FPEC_ROW_TIME_NS));
						end else if (!noop && op_reg == `FPEC_OP_WORD) begin
							state_reg <= FPEC_STREAM;
							base_reg <= tab_addr;
							idx_reg <= {1'b0, offs_reg[6:1]};
							last_reg <= 1'b1;
							cnt_reg <= 16'(`FPEC_CYC(`FPEC_WORD_TIME_NS));
						end else if (!noop && op_reg == `FPEC_OP_PAGE) begin
							cnt_reg <= 16'(PAGE_CYCLES);
						end else if (!noop) begin
							cnt_reg <= 16'(BULK_CYCLES);
						end
					end
				end
				FPEC_STREAM: begin
					cnt_reg <= cnt_reg - 16'h1;
					idx_reg <= idx_reg + 7'h1;
					if (last_reg || idx_reg == `FPEC_ROW_WORDS - 7'h1) begin
						state_reg <= FPEC_WAIT;
					end
				end
				FPEC_WAIT: begin
					if (cnt_reg == 16'h0) begin
						state_reg <= FPEC_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 16'h1;
					end
				end
				default: state_reg <= FPEC_IDLE;
			endcase
		end
	end
	assign cpu_stall = busy;
	// array strobes and data, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_erase <= 1'b0;
			flash_bulk <= 1'b0;
			flash_wr_en <= 1'b0;
			flash_addr <= 24'h0;
			flash_wdata <= 24'h0;
		end else begin
			flash_erase <= go && !noop && erase_reg;
			flash_bulk <= go && !noop && op_reg == `FPEC_OP_BULK;
			flash_wr_en <= state_reg == FPEC_STREAM && !abort;
			if (go && erase_reg) begin
				flash_addr <= tab_addr & ~`FPEC_BLOCK_MASK;
			end else if (state_reg == FPEC_STREAM) begin
				flash_addr <= last_reg ? base_reg : base_reg | {16'h0, idx_reg, 1'b0};
				flash_wdata <= latch_mem[idx_reg[5:0]];
			end
		end
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_go_starts: assert property (@(posedge aclk) disable iff (!aresetn)
		go && !sys_reset_req |=> wr_reg && cpu_stall)
		else $error("trigger did not start operation");
	a_wr_tracks_busy: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_reg == cpu_stall)
		else $error("trigger bit and stall disagree");
	a_bad_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		bad |=> err_reg && !wr_reg)
		else $error("improper trigger not flagged");
	a_no_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		set_try && !program_erase_enable_reg |=> !cpu_stall)
		else $error("operation started while inhibited");
	a_keys_needed: assert property (@(posedge aclk) disable iff (!aresetn)
		set_try && key_reg != 2'h2 |=> !wr_reg ##1 !wr_reg)
		else $error("operation started without keys");
	a_key_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && raddr_reg == `FPEC_KEY_OFS |-> rdata == 32'h0)
		else $error("key port readable");
	a_row_streams: assert property (@(posedge aclk) disable iff (!aresetn)
		go && !noop && op_reg == `FPEC_OP_ROW && !sys_reset_req
		|=> ##1 flash_wr_en [*8])
		else $error("row latches not streamed");
	a_erase_aligned: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_erase |-> flash_addr[9:0] == 10'h0 && !flash_wr_en)
		else $error("erase block misaligned");
	a_noop_short: assert property (@(posedge aclk) disable iff (!aresetn)
		go && noop && !sys_reset_req |=> cpu_stall ##1 !cpu_stall)
		else $error("no-operation code took too long");
endmodule // fpec_top
`default_nettype wire

// [tb/tb_fpec_top.sv]
// self-checking bench of the flash program/erase control
`timescale 1ns/1ps
`default_nettype none
`include "fpec_regs.svh"
module tb_fpec_top;
	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	localparam int PGC = 20; // shortened erase count
	localparam int BKC = 20; // shortened bulk count
	localparam logic [7:0] CT = `FPEC_CTRL_OFS; // control offset
	localparam logic [7:0] KY = `FPEC_KEY_OFS; // key offset
	localparam logic [7:0] PG = `FPEC_PAGE_OFS; // page offset
	localparam logic [7:0] OF = `FPEC_OFFS_OFS; // offset register
	logic aclk = 1'h0, aresetn = 1'h0; // clock, power-on reset
	logic sys_reset_req = 1'h0, serial_prog_pin = 1'h0; // side inputs
	logic [7:0] awaddr = 8'h00, araddr = 8'h00; // addresses
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0; // write side
	logic arvalid = 1'h0, rready = 1'h0; // read side
	logic [31:0] wdata = 32'h0; // write data
	logic [3:0] wstrb = 4'h0; // strobes
	logic awready, wready, bvalid, arready, rvalid; // slave handshakes
	logic [1:0] bresp, rresp; // responses
	logic [31:0] rdata, rd; // read data, last read
	logic [1:0] rs; // last response
	logic cpu_stall, flash_erase, flash_bulk, flash_wr_en; // strobes
	logic [23:0] flash_addr, flash_wdata, wr_a, wr_d, er_a; // array bus
	int mismatches = 0, n_tests = 0; // tallies
	int n_st = 0, n_wr = 0, n_er = 0, n_bk = 0; // event counts
	int s_st, s_wr, s_er, s_bk; // snapshots
	always #2 aclk = ~aclk; // 250 MHz
	fpec_top #(.PAGE_CYCLES(PGC), .BULK_CYCLES(BKC)) u_fpec_top (
		.aclk(aclk), .aresetn(aresetn), .sys_reset_req(sys_reset_req),
		.serial_prog_pin(serial_prog_pin), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cpu_stall(cpu_stall), .flash_erase(flash_erase),
		.flash_bulk(flash_bulk), .flash_wr_en(flash_wr_en),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata));
	// counts stall cycles and array strobes
	always @(posedge aclk) begin
		if (cpu_stall === 1'h1) n_st++;
		if (flash_wr_en === 1'h1) begin
			n_wr++;
			wr_a = flash_addr;
			wr_d = flash_wdata;
		end
		if (flash_erase === 1'h1) begin
			n_er++;
			er_a = flash_addr;
		end
		if (flash_bulk === 1'h1) n_bk++;
	end
	// ----------------------------------------------------------
	// bus and compare tasks
	// ----------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one write; ready sampled at negedge equals the next edge's value
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		bit ah, wh, bh;
		bh = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int n = 0; n < 100 && !bh; n++) begin
			@(negedge aclk);
			ah = awvalid && awready === 1'h1;
			wh = wvalid && wready === 1'h1;
			bh = bvalid === 1'h1;
			rs = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
			if (bh) bready <= 1'h0;
		end
		if (!bh) chk("write answer", 1, 0);
	endtask
	// one read, result left in rd and rs
	task automatic rdr(input logic [7:0] a);
		bit ah, rh;
		rh = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int n = 0; n < 100 && !rh; n++) begin
			@(negedge aclk);
			ah = arvalid && arready === 1'h1;
			rh = rvalid === 1'h1;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'h0;
			if (rh) rready <= 1'h0;
		end
		if (!rh) chk("read answer", 1, 0);
	endtask
	// setup, keys (mode 1 none, 2 broken, 3 reset between), trigger
	task automatic launch(input logic [15:0] c, input int mode);
		wr(CT, {16'h0, c}, 4'h3);
		s_st = n_st;
		s_wr = n_wr;
		s_er = n_er;
		s_bk = n_bk;
		if (mode != 1) wr(KY, {24'h0, `FPEC_KEY_FIRST}, 4'h1);
		if (mode == 2) wr(PG, 32'h0, 4'h1);
		if (mode == 3) begin
			sys_reset_req <= 1'h1;
			@(posedge aclk);
			sys_reset_req <= 1'h0;
		end
		if (mode != 1) wr(KY, {24'h0, `FPEC_KEY_SECOND}, 4'h1);
		wr(CT, {16'h0, c | 16'h8000}, 4'h3);
		// two idle slots after the trigger, as software would
		repeat (2) @(posedge aclk);
	endtask
	task automatic wait_idle;
		for (int n = 0; n < 1000 && cpu_stall !== 1'h0; n++)
			@(negedge aclk);
		chk("stall idle", 0, cpu_stall);
	endtask
	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	task automatic t_reset_map;
		rdr(CT);
		chk("ctrl reset", 0, rd);
		wr(KY, 32'h55, 4'h1);
		rdr(KY);
		chk("key read", 0, rd);
		wr(8'h14, 32'h0, 4'hF);
		chk("unmapped bresp", 2, rs);
		wr(8'h02, 32'h0, 4'hF);
		chk("unaligned bresp", 2, rs);
		rdr(8'h14);
		chk("unmapped rresp", 2, rs);
	endtask
	task automatic t_refuse;
		logic [15:0] c[6] = '{16'h4042, 16'h4042, 16'h4042, 16'h0042,
			16'h4005, 16'h404F};
		int m[6] = '{1, 2, 3, 0, 0, 0};
		for (int i = 0; i < 6; i++) begin
			launch(c[i], m[i]);
			wait_idle();
			rdr(CT);
			chk("refused ctrl", c[i] | 16'h2000, rd);
			chk("refused erase", 0, n_er - s_er);
			chk("refused write", 0, n_wr - s_wr);
		end
	endtask
	task automatic t_noop;
		logic [15:0] c[4] = '{16'h4041, 16'h4043, 16'h4002, 16'h400F};
		for (int i = 0; i < 4; i++) begin
			launch(c[i], 0);
			wait_idle();
			rdr(CT);
			chk("noop ctrl", c[i], rd);
			chk("noop stall", 1, n_st - s_st);
			chk("noop strobes", 0, n_er + n_wr - s_er - s_wr);
		end
	endtask
	task automatic t_row;
		wr(PG, 32'h0, 4'h1);
		wr(OF, 32'h90, 4'h3);
		launch(16'h4001, 0);
		rdr(CT);
		chk("row busy ctrl", 32'hC001, rd);
		chk("row stall", 1, cpu_stall);
		wait_idle();
		rdr(CT);
		chk("row done ctrl", 32'h4001, rd);
		chk("row words", 64, n_wr - s_wr);
		chk("row last addr", 24'h0000FE, wr_a);
		chk("row long stall", 1, n_st - s_st >= 500);
	endtask
	task automatic t_page;
		wr(OF, 32'h456, 4'h3);
		launch(16'h4042, 0);
		wait_idle();
		chk("page erase", 1, n_er - s_er);
		chk("page base", 24'h000400, er_a);
		chk("page stall", PGC + 1, n_st - s_st);
	endtask
	task automatic t_word;
		wr(PG, 32'h1, 4'h1);
		wr(OF, 32'h204, 4'h3);
		wr(`FPEC_LATCH_OFS, 32'h00ABCDEF, 4'h7);
		chk("latch held", 0, n_wr - s_wr);
		wr(OF, 32'h204, 4'h3);
		launch(16'h4003, 0);
		wait_idle();
		chk("word count", 1, n_wr - s_wr);
		chk("word addr", 24'h010204, wr_a);
		chk("word data", 24'hABCDEF, wr_d);
	endtask
	task automatic t_bulk_abort;
		@(posedge aclk);
		serial_prog_pin <= 1'h1;
		repeat (3) @(posedge aclk);
		launch(16'h404F, 0);
		wait_idle();
		chk("bulk erase", 2, n_er + n_bk - s_er - s_bk);
		chk("bulk stall", BKC + 1, n_st - s_st);
		@(posedge aclk);
		serial_prog_pin <= 1'h0;
		launch(16'h4042, 0);
		sys_reset_req <= 1'h1;
		@(posedge aclk);
		sys_reset_req <= 1'h0;
		wait_idle();
		rdr(CT);
		chk("aborted ctrl", 32'h6042, rd);
	endtask
	// ----------------------------------------------------------
	// sequence, watchdog, verdict
	// ----------------------------------------------------------
	task automatic end_of_test;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset_map();
		t_refuse();
		t_noop();
		t_row();
		t_page();
		t_word();
		t_bulk_abort();
		end_of_test();
	end
	// cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		end_of_test();
	end
endmodule // tb_fpec_top
`default_nettype wire
